// [src/status_flags_and_gp_pin_mux.sv]
// Status flag registers and function multiplexer of the first general pin.
// Assumes a simple register port from the control bus decoder on the core clock;
// analog status lines, the pin and the two source clocks are asynchronous.
`timescale 1ns/1ps

module status_flags_and_gp_pin_mux #(
    parameter int PULSE_CYCLES  = first_pin_pkg::PULSE_CYCLES,
    parameter int BUTTON_CYCLES = first_pin_pkg::BUTTON_CYCLES
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_reset_n,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic       i_reg_wr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_reg_rd,
    output logic [7:0]      o_reg_rdata,
    output logic            o_reg_rvalid,
    input  wire logic [3:0] i_driver_short,
    input  wire logic [1:0] i_common_powered,
    input  wire logic       i_headset_present,
    input  wire logic       i_button_pressed,
    input  wire logic [1:0] i_agc_below_noise,
    input  wire logic [6:0] i_module_powered,
    input  wire logic       i_pll_clk,
    input  wire logic       i_divmux_clk,
    input  wire logic       i_adc_word_clk,
    input  wire logic       i_word_clk,
    input  wire logic       i_word_clk_drive,
    input  wire logic       i_pin_in,
    output logic            o_pin_out,
    output logic            o_pin_oe,
    output logic            o_word_clk_from_pin
);

    localparam int CNT_W = $clog2(PULSE_CYCLES + 1);
    localparam int BTN_W = $clog2(BUTTON_CYCLES + 1);

    typedef enum logic [2:0] {
        GEN_IDLE = 3'b001,
        GEN_HIGH = 3'b010,
        GEN_LOW  = 3'b100
    } pulse_state_t;

    // Interrupt sources in the order headset, short circuit, AGC noise.
    function automatic logic [2:0] pulse_sources(input logic [3:0] code);
        unique case (code)
            first_pin_pkg::FN_SHORT_IRQ: pulse_sources = 3'b010;
            first_pin_pkg::FN_AGC_IRQ:   pulse_sources = 3'b001;
            first_pin_pkg::FN_HS_IRQ:    pulse_sources = 3'b100;
            first_pin_pkg::FN_HS_BTN:    pulse_sources = 3'b100;
            first_pin_pkg::FN_ALL_IRQ:   pulse_sources = 3'b111;
            default:                     pulse_sources = 3'b000;
        endcase
    endfunction : pulse_sources

    function automatic logic [1:0] divider_ratio(input logic [3:0] code);
        unique case (code)
            first_pin_pkg::FN_CLK_DIV2: divider_ratio = first_pin_pkg::RATIO_2;
            first_pin_pkg::FN_CLK_DIV4: divider_ratio = first_pin_pkg::RATIO_4;
            first_pin_pkg::FN_CLK_DIV8: divider_ratio = first_pin_pkg::RATIO_8;
            default:                    divider_ratio = first_pin_pkg::RATIO_1;
        endcase
    endfunction : divider_ratio

    logic [first_pin_pkg::SYNC_W-1:0] async_in;
    logic [first_pin_pkg::SYNC_W-1:0] sync1_q;
    logic [first_pin_pkg::SYNC_W-1:0] sync2_q;
    logic [7:0]                       ctrl_q;
    logic                             btn_sticky_q;
    logic                             btn_prev_q;
    logic [BTN_W-1:0]                 btn_cnt_q;
    logic                             btn_qual_q;
    logic [3:0]                       short_prev_q;
    logic [1:0]                       agc_prev_q;
    logic                             hs_prev_q;
    logic                             pending_q;
    pulse_state_t                     state_q;
    pulse_state_t                     state_d;
    logic [CNT_W-1:0]                 pulse_cnt_q;
    logic                             div_level;
    logic                             pin_out_d;
    logic                             pin_oe_d;

    assign async_in = {i_driver_short, i_common_powered, i_headset_present, i_button_pressed,
                       i_agc_below_noise, i_module_powered, i_pin_in, i_pll_clk, i_divmux_clk};

    // Every asynchronous line passes two flip-flops before use.
    for (genvar g = 0; g < first_pin_pkg::SYNC_W; g++) begin : g_sync
        always_ff @(posedge i_core_clk) begin
            if (!i_reset_n) begin
                sync1_q[g] <= 1'b0;
                sync2_q[g] <= 1'b0;
            end else begin
                sync1_q[g] <= async_in[g];
                sync2_q[g] <= sync1_q[g];
            end
        end
    end

    wire [3:0] short_s   = sync2_q[first_pin_pkg::IX_SHORT +: 4];
    wire [1:0] compwr_s  = sync2_q[first_pin_pkg::IX_COMPWR +: 2];
    wire       headset_s = sync2_q[first_pin_pkg::IX_HEADSET];
    wire       button_s  = sync2_q[first_pin_pkg::IX_BUTTON];
    wire [1:0] agc_s     = sync2_q[first_pin_pkg::IX_AGC +: 2];
    wire [6:0] modpwr_s  = sync2_q[first_pin_pkg::IX_MODPWR +: 7];
    wire       pin_s     = sync2_q[first_pin_pkg::IX_PIN];
    wire       pll_s     = sync2_q[first_pin_pkg::IX_PLL];
    wire       divmux_s  = sync2_q[first_pin_pkg::IX_DIVMUX];

    wire [3:0] func      = ctrl_q[first_pin_pkg::FUNC_MSB:first_pin_pkg::FUNC_LSB];
    wire       repeat_on = ctrl_q[first_pin_pkg::INT_FORM_BIT];
    wire       gp_level  = ctrl_q[first_pin_pkg::PIN_OUT_BIT];

    // Register port decode.
    wire rd_button_clr = i_reg_rd && (i_reg_addr == first_pin_pkg::ADDR_BUTTON_CLEAR);
    wire rd_int_flags  = i_reg_rd && (i_reg_addr == first_pin_pkg::ADDR_INT_FLAGS);
    wire wr_pin_ctrl   = i_reg_wr && (i_reg_addr == first_pin_pkg::ADDR_PIN_CTRL);

    wire [7:0] driver_word = {short_s, compwr_s, first_pin_pkg::RESERVED_VALUE};
    wire [7:0] live_word   = {short_s, btn_sticky_q, headset_s, agc_s};
    wire [7:0] ctrl_word   = {ctrl_q[7:2], pin_s, gp_level};
    wire [7:0] rdata_d     =
        (i_reg_addr == first_pin_pkg::ADDR_MODULE_POWER) ? {modpwr_s, 1'b0} :
        (i_reg_addr == first_pin_pkg::ADDR_DRIVER_STATE) ? driver_word :
        (i_reg_addr == first_pin_pkg::ADDR_LIVE_FLAGS)   ? live_word :
        (i_reg_addr == first_pin_pkg::ADDR_PIN_CTRL)     ? ctrl_word : 8'h00;

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_reg_rdata  <= first_pin_pkg::STATUS_RESET;
            o_reg_rvalid <= 1'b0;
            ctrl_q       <= first_pin_pkg::PIN_CTRL_RESET;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= rdata_d;
            end
            if (wr_pin_ctrl) begin
                ctrl_q <= {i_reg_wdata[7:2], 1'b0, i_reg_wdata[first_pin_pkg::PIN_OUT_BIT]};
            end
        end
    end

    // Button press events; the sticky flag lets a new press win over the clearing read.
    wire btn_set = button_s & ~btn_prev_q;
    wire btn_hit = (btn_cnt_q == BTN_W'(BUTTON_CYCLES));

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            btn_prev_q   <= 1'b0;
            btn_sticky_q <= 1'b0;
            btn_cnt_q    <= '0;
            btn_qual_q   <= 1'b0;
        end else begin
            btn_prev_q <= button_s;
            if (btn_set) begin
                btn_sticky_q <= 1'b1;
            end else if (rd_button_clr) begin
                btn_sticky_q <= 1'b0;
            end
            if (!button_s) begin
                btn_cnt_q <= '0;
            end else if (!btn_hit) begin
                btn_cnt_q <= btn_cnt_q + BTN_W'(1);
            end
            btn_qual_q <= button_s && btn_hit;
        end
    end

    // Interrupt events on the pin.
    wire       short_evt = |(short_s & ~short_prev_q);
    wire       agc_evt   = |(agc_s & ~agc_prev_q);
    wire       hs_evt    = headset_s ^ hs_prev_q;
    wire [2:0] src_sel   = pulse_sources(func);
    wire       irq_evt   = |(src_sel & {hs_evt, short_evt, agc_evt});
    wire       cnt_end   = (pulse_cnt_q == CNT_W'(PULSE_CYCLES - 1));
    wire       gen_high  = (state_q == GEN_HIGH);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            GEN_IDLE: if (irq_evt) state_d = GEN_HIGH;
            GEN_HIGH: if (cnt_end) state_d = GEN_LOW;
            GEN_LOW:  if (cnt_end) state_d = (pending_q || irq_evt) ? GEN_HIGH : GEN_IDLE;
            default:  state_d = GEN_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            short_prev_q <= 4'h0;
            agc_prev_q   <= 2'h0;
            hs_prev_q    <= 1'b0;
            pending_q    <= 1'b0;
            state_q      <= GEN_IDLE;
            pulse_cnt_q  <= '0;
        end else begin
            short_prev_q <= short_s;
            agc_prev_q   <= agc_s;
            hs_prev_q    <= headset_s;
            if (irq_evt && repeat_on) begin
                pending_q <= 1'b1;
            end else if (rd_int_flags || !repeat_on) begin
                pending_q <= 1'b0;
            end
            state_q     <= state_d;
            pulse_cnt_q <= (state_d != state_q) ? '0 : pulse_cnt_q + CNT_W'(1);
        end
    end

    pin_clock_divider u_divider (
        .i_core_clk  (i_core_clk),
        .i_reset_n   (i_reset_n),
        .i_src_level (ctrl_q[first_pin_pkg::CLK_SEL_BIT] ? divmux_s : pll_s),
        .i_ratio_sel (divider_ratio(func)),
        .o_div_level (div_level)
    );

    // Pin function multiplexer.
    always_comb begin
        pin_out_d = 1'b0;
        pin_oe_d  = 1'b1;
        unique case (func)
            first_pin_pkg::FN_OFF:       pin_oe_d  = 1'b0;
            first_pin_pkg::FN_ADC_WCLK:  pin_out_d = i_adc_word_clk;
            first_pin_pkg::FN_CLK_DIV1:  pin_out_d = div_level;
            first_pin_pkg::FN_CLK_DIV2:  pin_out_d = div_level;
            first_pin_pkg::FN_CLK_DIV4:  pin_out_d = div_level;
            first_pin_pkg::FN_CLK_DIV8:  pin_out_d = div_level;
            first_pin_pkg::FN_SHORT_IRQ: pin_out_d = gen_high;
            first_pin_pkg::FN_AGC_IRQ:   pin_out_d = gen_high;
            first_pin_pkg::FN_GP_IN:     pin_oe_d  = 1'b0;
            first_pin_pkg::FN_GP_OUT:    pin_out_d = gp_level;
            first_pin_pkg::FN_GP_OUT_X:  pin_out_d = gp_level;
            first_pin_pkg::FN_WORD_CLK: begin
                pin_out_d = i_word_clk;
                pin_oe_d  = i_word_clk_drive;
            end
            first_pin_pkg::FN_BTN_IRQ:   pin_out_d = btn_qual_q;
            first_pin_pkg::FN_HS_IRQ:    pin_out_d = gen_high;
            first_pin_pkg::FN_HS_BTN:    pin_out_d = gen_high | btn_qual_q;
            first_pin_pkg::FN_ALL_IRQ:   pin_out_d = gen_high | btn_qual_q;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_pin_out           <= 1'b0;
            o_pin_oe            <= 1'b0;
            o_word_clk_from_pin <= 1'b0;
        end else begin
            o_pin_out           <= pin_out_d;
            o_pin_oe            <= pin_oe_d;
            o_word_clk_from_pin <= pin_s;
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    sequence driver_read_s;
        i_reg_rd && (i_reg_addr == first_pin_pkg::ADDR_DRIVER_STATE);
    endsequence

    sequence live_read_s;
        i_reg_rd && (i_reg_addr == first_pin_pkg::ADDR_LIVE_FLAGS);
    endsequence

    driver_word_a: assert property (driver_read_s |=> o_reg_rvalid &&
        o_reg_rdata[7:2] == $past({short_s, compwr_s}))
        else $error("Driver status read does not match short and power state.");

    reserved_low_a: assert property (driver_read_s |=> o_reg_rdata[1:0] == 2'h0)
        else $error("Reserved driver status bits are not zero.");

    live_word_a: assert property (live_read_s |=>
        {o_reg_rdata[7:4], o_reg_rdata[2:0]} == $past({short_s, headset_s, agc_s}))
        else $error("Live flag read does not mirror live state.");

    sticky_hold_a: assert property (btn_sticky_q && !rd_button_clr |=> btn_sticky_q)
        else $error("Button flag dropped without a clearing read.");

    sticky_clear_a: assert property (rd_button_clr && !btn_set |=> !btn_sticky_q)
        else $error("Button flag not cleared by its read.");

    pin_off_a: assert property (func == first_pin_pkg::FN_OFF && $stable(func)
        |=> !o_pin_oe)
        else $error("Disabled pin is driven.");

    gp_output_a: assert property ((func == first_pin_pkg::FN_GP_OUT ||
        func == first_pin_pkg::FN_GP_OUT_X) |=> o_pin_oe && o_pin_out == $past(gp_level))
        else $error("General output level not on the pin.");

    gp_input_a: assert property (i_reg_rd && i_reg_addr == first_pin_pkg::ADDR_PIN_CTRL
        |=> o_reg_rdata[first_pin_pkg::PIN_IN_BIT] == $past(pin_s))
        else $error("Pin input value not returned.");

    pulse_end_a: assert property (gen_high && cnt_end |=> state_q == GEN_LOW)
        else $error("Interrupt pulse does not end after its length.");

    pulse_start_a: assert property (state_q == GEN_IDLE && irq_evt
        |=> gen_high ##1 (func != $past(func, 2)) || o_pin_out)
        else $error("Interrupt event did not start a pulse on the pin.");

endmodule : status_flags_and_gp_pin_mux

// [src/first_pin_pkg.sv]
// Constants shared by the status flag and first general pin logic.
// Assumes a 40 MHz core clock; all offsets are page 0 register addresses.
package first_pin_pkg;

    // Register addresses.
    localparam logic [7:0] ADDR_BUTTON_CLEAR = 8'h0e;
    localparam logic [7:0] ADDR_MODULE_POWER = 8'h5e;
    localparam logic [7:0] ADDR_DRIVER_STATE = 8'h5f;
    localparam logic [7:0] ADDR_INT_FLAGS    = 8'h60;
    localparam logic [7:0] ADDR_LIVE_FLAGS   = 8'h61;
    localparam logic [7:0] ADDR_PIN_CTRL     = 8'h62;

    // Reset values.
    localparam logic [7:0] STATUS_RESET   = 8'h00;
    localparam logic [7:0] PIN_CTRL_RESET = 8'h00;
    localparam logic [1:0] RESERVED_VALUE = 2'h0;

    // Pin control field positions.
    localparam int FUNC_MSB     = 7;
    localparam int FUNC_LSB     = 4;
    localparam int CLK_SEL_BIT  = 3;
    localparam int INT_FORM_BIT = 2;
    localparam int PIN_IN_BIT   = 1;
    localparam int PIN_OUT_BIT  = 0;

    // Pin function codes.
    localparam logic [3:0] FN_OFF       = 4'h0;
    localparam logic [3:0] FN_ADC_WCLK  = 4'h1;
    localparam logic [3:0] FN_CLK_DIV1  = 4'h2;
    localparam logic [3:0] FN_CLK_DIV2  = 4'h3;
    localparam logic [3:0] FN_CLK_DIV4  = 4'h4;
    localparam logic [3:0] FN_CLK_DIV8  = 4'h5;
    localparam logic [3:0] FN_SHORT_IRQ = 4'h6;
    localparam logic [3:0] FN_AGC_IRQ   = 4'h7;
    localparam logic [3:0] FN_GP_IN     = 4'h8;
    localparam logic [3:0] FN_GP_OUT    = 4'h9;
    localparam logic [3:0] FN_GP_OUT_X  = 4'ha;
    localparam logic [3:0] FN_WORD_CLK  = 4'hb;
    localparam logic [3:0] FN_BTN_IRQ   = 4'hc;
    localparam logic [3:0] FN_HS_IRQ    = 4'hd;
    localparam logic [3:0] FN_HS_BTN    = 4'he;
    localparam logic [3:0] FN_ALL_IRQ   = 4'hf;

    // Divider ratio selects.
    localparam logic [1:0] RATIO_1 = 2'h0;
    localparam logic [1:0] RATIO_2 = 2'h1;
    localparam logic [1:0] RATIO_4 = 2'h2;
    localparam logic [1:0] RATIO_8 = 2'h3;

    // Positions in the synchronised input vector.
    localparam int SYNC_W      = 20;
    localparam int IX_SHORT    = 16;
    localparam int IX_COMPWR   = 14;
    localparam int IX_HEADSET  = 13;
    localparam int IX_BUTTON   = 12;
    localparam int IX_AGC      = 10;
    localparam int IX_MODPWR   = 3;
    localparam int IX_PIN      = 2;
    localparam int IX_PLL      = 1;
    localparam int IX_DIVMUX   = 0;

    // Timing.
    localparam int CLK_HZ          = 40_000_000;
    localparam int PULSE_US        = 2000;
    localparam int BUTTON_DELAY_US = 500;
    localparam int PULSE_CYCLES    = (CLK_HZ / 1_000_000) * PULSE_US;
    localparam int BUTTON_CYCLES   = (CLK_HZ / 1_000_000) * BUTTON_DELAY_US;

endpackage : first_pin_pkg

// [src/pin_clock_divider.sv]
// Divides a synchronised clock level by 1, 2, 4 or 8 for the first general pin.
// Assumes its input has already passed a two-stage synchroniser on the core clock.
`timescale 1ns/1ps
module pin_clock_divider (
    input  wire logic       i_core_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_src_level,
    input  wire logic [1:0] i_ratio_sel,
    output logic            o_div_level
);

    logic       src_prev_q;
    logic [1:0] edge_cnt_q;
    logic [1:0] edge_cnt_d;
    logic       half_q;
    logic       half_d;
    logic [1:0] cnt_mask;
    wire        src_rise = i_src_level & ~src_prev_q;

    // Half a divided period is 1, 2 or 4 source rising edges.
    assign cnt_mask   = (i_ratio_sel == first_pin_pkg::RATIO_8) ? 2'h3 :
                        (i_ratio_sel == first_pin_pkg::RATIO_4) ? 2'h1 : 2'h0;
    assign edge_cnt_d = ((edge_cnt_q & cnt_mask) == cnt_mask) ? 2'h0 : edge_cnt_q + 2'h1;
    assign half_d     = ((edge_cnt_q & cnt_mask) == cnt_mask) ? ~half_q : half_q;

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            src_prev_q  <= 1'b0;
            edge_cnt_q  <= 2'h0;
            half_q      <= 1'b0;
            o_div_level <= 1'b0;
        end else begin
            src_prev_q <= i_src_level;
            if (src_rise) begin
                edge_cnt_q <= edge_cnt_d;
                half_q     <= half_d;
            end
            o_div_level <= (i_ratio_sel == first_pin_pkg::RATIO_1) ? i_src_level : half_q;
        end
    end

endmodule : pin_clock_divider

// [tb/pin_host_model.sv]
// Host-side model of what watches or drives the first general pin.
// Assumes the design drives the pin only while its enable is high.
`timescale 1ns/1ps
module pin_host_model (
    input  wire logic i_core_clk,
    input  wire logic i_pin_out,
    input  wire logic i_pin_oe,
    input  wire logic i_host_drive,
    input  wire logic i_host_level,
    input  wire logic i_clear,
    output logic      o_pin_in,
    output int        o_high_cnt,
    output int        o_rise_cnt
);
    logic tog_q = 1'b0;
    logic prev_q = 1'b0;
    wire  seen = i_pin_oe & i_pin_out;
    // An undriven pin has no pull, so it shows a level that changes every cycle.
    assign o_pin_in = i_pin_oe ? i_pin_out : (i_host_drive ? i_host_level : tog_q);
    always_ff @(posedge i_core_clk) begin
        tog_q  <= ~tog_q;
        prev_q <= seen;
        if (i_clear) begin
            o_high_cnt <= 0;
            o_rise_cnt <= 0;
        end else begin
            o_high_cnt <= o_high_cnt + int'(seen);
            o_rise_cnt <= o_rise_cnt + int'(seen & ~prev_q);
        end
    end
endmodule : pin_host_model

// [tb/tb_top.sv]
// Self-checking bench for the status flags and first general pin multiplexer.
// Assumes shortened pulse and button counts and a host model on the pin.
`timescale 1ns/1ps
module tb_top;
    localparam int PC = 8;
    localparam int BC = 4;
    typedef struct packed {
        logic [3:0] s; logic [1:0] p; logic h; logic [1:0] g;
        logic [6:0] m; logic [7:0] a; logic [7:0] e;
    } row_t;
    row_t rows [7] = '{'{4'h0, 2'h0, 1'h0, 2'h0, 7'h00, 8'h5f, 8'h00},
        '{4'ha, 2'h1, 1'h0, 2'h0, 7'h00, 8'h5f, 8'ha4},
        '{4'h5, 2'h2, 1'h0, 2'h0, 7'h00, 8'h5f, 8'h58},
        '{4'ha, 2'h0, 1'h1, 2'h1, 7'h00, 8'h61, 8'ha5},
        '{4'h5, 2'h0, 1'h0, 2'h2, 7'h00, 8'h61, 8'h52},
        '{4'h0, 2'h0, 1'h0, 2'h0, 7'h55, 8'h5e, 8'haa},
        '{4'h0, 2'h0, 1'h0, 2'h0, 7'h00, 8'h40, 8'h00}};
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, hs = 0, btn = 0, pll = 0, dm = 0;
    logic adcw = 0, wc = 0, wcd = 0, hd = 0, hl = 0, clr = 0;
    logic [7:0] addr = 0, wdata = 0;
    logic [3:0] sh = 0;
    logic [1:0] pw = 0, agc = 0;
    logic [6:0] mp = 0;
    wire [7:0] rdata;
    wire rvalid, pin_in, pout, poe, wfp;
    int hi, ri, mismatches = 0, cmp_count = 0;
    status_flags_and_gp_pin_mux #(.PULSE_CYCLES(PC), .BUTTON_CYCLES(BC))
        status_flags_and_gp_pin_mux_i (
        .i_core_clk(clk), .i_reset_n(rst_n), .i_reg_addr(addr), .i_reg_wr(wr),
        .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .i_driver_short(sh), .i_common_powered(pw), .i_headset_present(hs),
        .i_button_pressed(btn), .i_agc_below_noise(agc), .i_module_powered(mp),
        .i_pll_clk(pll), .i_divmux_clk(dm), .i_adc_word_clk(adcw), .i_word_clk(wc),
        .i_word_clk_drive(wcd), .i_pin_in(pin_in), .o_pin_out(pout), .o_pin_oe(poe),
        .o_word_clk_from_pin(wfp));
    pin_host_model pin_host_model_i (.i_core_clk(clk), .i_pin_out(pout), .i_pin_oe(poe),
        .i_host_drive(hd), .i_host_level(hl), .i_clear(clr), .o_pin_in(pin_in),
        .o_high_cnt(hi), .o_rise_cnt(ri));
    initial forever #12.5 clk = ~clk;
    task automatic finish_test();
        if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk); #2 addr = a; wdata = d; wr = 1;
        @(posedge clk); #2 wr = 0;
    endtask : reg_wr
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk); #2 addr = a; rd = 1;
        @(posedge clk); #2 rd = 0;
        chk({7'h0, rvalid}, 8'h01);
        chk(rdata, e);
    endtask : rd_chk
    task automatic start_count();
        clr = 1; tick(1); clr = 0;
    endtask : start_count
    task automatic spin(input logic use_dm, input int exp);
        start_count();
        repeat (32) begin
            tick(4);
            if (use_dm) dm = ~dm; else pll = ~pll;
        end
        chk(8'(int'(ri >= exp - 1 && ri <= exp + 1)), 8'h01);
    endtask : spin
    initial begin
        #(25 * 20000); mismatches++; finish_test();
    end
    initial begin
        tick(6); rst_n = 1;
        foreach (rows[i]) begin
            {sh, pw, hs, agc, mp} = {rows[i].s, rows[i].p, rows[i].h, rows[i].g, rows[i].m};
            tick(4); rd_chk(rows[i].a, rows[i].e);
        end
        {sh, pw, hs, agc, mp} = 0;
        // Software never writes the driver status register.
        reg_wr(8'h62, 8'ha1); tick(2); chk({6'h0, poe, pout}, 8'h03);
        reg_wr(8'h62, 8'h90); tick(2); chk({6'h0, poe, pout}, 8'h02);
        reg_wr(8'h62, 8'h00); tick(2); chk({7'h0, poe}, 8'h00);
        reg_wr(8'h62, 8'h82); hd = 1; hl = 1; tick(4); rd_chk(8'h62, 8'h82);
        hl = 0; tick(4); rd_chk(8'h62, 8'h80); chk({7'h0, poe}, 8'h00);
        reg_wr(8'h62, 8'h10); adcw = 1; tick(3); chk({6'h0, poe, pout}, 8'h03);
        adcw = 0; tick(3); chk({6'h0, poe, pout}, 8'h02);
        reg_wr(8'h62, 8'hb0); wcd = 1; wc = 1; tick(3); chk({6'h0, poe, pout}, 8'h03);
        wcd = 0; hl = 1; tick(4); chk({6'h0, poe, wfp}, 8'h01);
        hd = 0;
        for (int k = 0; k < 4; k++) begin
            reg_wr(8'h62, {4'(2 + k), 4'h0}); spin(1'b0, 16 >> k);
        end
        reg_wr(8'h62, 8'h38); spin(1'b0, 0); spin(1'b1, 8);
        for (int i = 0; i < 5; i++) begin
            reg_wr(8'h62, {(i == 0) ? 4'h6 : (i == 1) ? 4'h7 : (i == 2) ? 4'hd :
                           (i == 3) ? 4'hf : 4'he, 4'h0});
            tick(20); start_count();
            case (i)
                0: sh[0] = 1;
                1: agc[0] = 1;
                2: hs = 1;
                3: sh[1] = 1;
                default: hs = 0;
            endcase
            tick(40); chk(hi[7:0], 8'(PC));
        end
        reg_wr(8'h62, 8'h64); tick(20); start_count(); sh[2] = 1;
        tick(60); chk(8'(int'(hi > PC)), 8'h01);
        rd_chk(8'h60, 8'h00); tick(20); start_count(); tick(40); chk(hi[7:0], 8'h00);
        reg_wr(8'h62, 8'hc0); tick(4); btn = 1; tick(2); chk({7'h0, pout}, 8'h00);
        tick(BC + 6); chk({7'h0, pout}, 8'h01);
        btn = 0; tick(6); chk({7'h0, pout}, 8'h00);
        rd_chk(8'h61, 8'h79); rd_chk(8'h61, 8'h79);
        rd_chk(8'h0e, 8'h00); tick(1); rd_chk(8'h61, 8'h71);
        // The host holds the pin low so the read-back input bit is known after reset.
        hd = 1; hl = 0;
        reg_wr(8'h62, 8'h91); rst_n = 0; tick(6); rst_n = 1; tick(1);
        chk({7'h0, poe}, 8'h00); rd_chk(8'h62, 8'h00);
        finish_test();
    end
endmodule : tb_top
